//--- logic/virt_control_capability_check.sv
// Capability report registers and entry-time control check, reached over
// Avalon-MM. Assumes a master that holds each request until waitrequest low.
//
// Overview of operation
// [RL1] Low capability bit X set: check fails when control X is 0.
// [RL2] Capability bit 32+X set allows control X at 1, else 1 fails.
// [RL3] Legacy primary report reads 1 at bits 1, 4-6, 8, 13-16, 26.
// [RL4] With bit 55 clear, fixed-one controls must be 1; true reports absent.
// [RL5] With bit 55 set, true reports hold all allowed settings, no exceptions.
// [RL6] Secondary report low half is always 0.
// [RL7] Reserved secondary bits must be 0, never reported as allowed at 1.
// [RL8] Secondary violations fail only while second-tier enable is 1.
// [RL9] Secondary report exists only when primary bit 63 is 1.
// [RL10] Tertiary report gives allowed 1-settings at bit X, gated by enable.
// [RL11] Tertiary report exists only when primary bit 49 is 1.
// [RL12] Legacy exit report reads 1 at bits 0-8, 10, 11, 13, 14, 16, 17.
// [RL13] Legacy entry report reads 1 at bits 0-8 and 12.
// [RL14] Entry control X at 1 with capability bit 32+X clear fails.
// [RL15] Primary reports at indices 482H legacy and 48EH true.
// [RL16] Exit reports at indices 483H legacy and 48FH true.
// [RL17] Entry reports at indices 484H legacy and 490H true.
// [RL18] Secondary report at index 48BH, tertiary at 492H.
// [RL19] Fixed-one class controls default to 1 for plain software.
// [RL20] Reports are fixed read-only; all violations merge into one result. Basic bit 55 is writable here.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module virt_control_capability_check (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire virt_cap_pkg::avalon_req_type  busReq,
    output var  virt_cap_pkg::avalon_rsp_type  busRsp,
    output var  logic                          entryDone,
    output var  logic                          entryFail
);
    import virt_cap_pkg::*;

    typedef enum logic [1:0] {
        CHK_IDLE   = 2'b00,
        CHK_EVAL   = 2'b01
    } check_state_type;

    typedef struct packed {
        logic              waitReq;
        logic [31:0]       readData;
        logic              basicTrue;
        logic [31:0]       priCtl;
        logic [31:0]       secCtl;
        logic [63:0]       terCtl;
        logic [31:0]       exitCtl;
        logic [31:0]       entryCtl;
        check_state_type   chk;
        logic [ST_W-1:0]   status;
    } state_type;

    state_type st;
    state_type next_st;

    logic [63:0] priSel;
    logic [63:0] exitSel;
    logic [63:0] entrySel;
    logic        secEnable;
    logic        terEnable;
    logic [4:0]  groupFail;
    logic        ack;
    logic        wordHit;
    logic [31:0] wordData;

    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0]  lanes
    );
        logic [31:0] merged;
        merged = oldWord;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                merged[i*8 +: 8] = newWord[i*8 +: 8];
            end
        end
        return merged;
    endfunction : mergeBytes

    function automatic logic [ADDR_W-1:0] lowAddr(input logic [11:0] idx);
        return {idx, 2'b00};
    endfunction : lowAddr

    function automatic logic [ADDR_W-1:0] highAddr(input logic [11:0] idx);
        return HIGH_HALF_BASE | {idx, 2'b00};
    endfunction : highAddr

    // One group's violations: low half forbids 0, high half allows 1
    function automatic logic groupViolation(
        input logic [63:0] cap,
        input logic [31:0] ctl
    );
        return |((~ctl & cap[31:0]) | (ctl & ~cap[63:32]));
    endfunction : groupViolation

    // Legacy reports carry the fixed-one bits forced high; with bit 55
    // clear they are the ones the check obeys.
    always_comb begin
        priSel = st.basicTrue ? PRI_TRUE : PRI_LEGACY; // see [RL4] [RL5]
        exitSel = st.basicTrue ? EXIT_TRUE : EXIT_LEGACY; // see [RL4] [RL5]
        entrySel = st.basicTrue ? ENTRY_TRUE : ENTRY_LEGACY; // see [RL5]
        secEnable = st.priCtl[SEC_ENABLE_BIT];
        terEnable = st.priCtl[TER_ENABLE_BIT];
        groupFail[0] = groupViolation(priSel, st.priCtl); // see [RL1] [RL2]
        groupFail[1] = secEnable
            && groupViolation(SEC_CAP, st.secCtl); // see [RL8] [RL7]
        groupFail[2] = terEnable
            && |(st.terCtl & ~TER_CAP); // see [RL10]
        groupFail[3] = groupViolation(exitSel, st.exitCtl); // see [RL1]
        groupFail[4] = groupViolation(entrySel, st.entryCtl); // see [RL14]
    end

    // Read decode; an absent report reads as zero
    always_comb begin
        wordHit = 1'b1;
        wordData = 32'h0000_0000;
        case (busReq.address & ~14'h0003)
            lowAddr(PRI_LEGACY_IDX): begin
                wordData = PRI_LEGACY[31:0]; // see [RL15] [RL3]
            end
            highAddr(PRI_LEGACY_IDX): wordData = PRI_LEGACY[63:32];
            lowAddr(EXIT_LEGACY_IDX): begin
                wordData = EXIT_LEGACY[31:0]; // see [RL16] [RL12]
            end
            highAddr(EXIT_LEGACY_IDX): wordData = EXIT_LEGACY[63:32];
            lowAddr(ENTRY_LEGACY_IDX): begin
                wordData = ENTRY_LEGACY[31:0]; // see [RL17] [RL13]
            end
            highAddr(ENTRY_LEGACY_IDX): wordData = ENTRY_LEGACY[63:32];
            lowAddr(SEC_IDX): begin
                wordData = 32'h0000_0000; // see [RL6]
            end
            highAddr(SEC_IDX): begin
                wordData = PRI_LEGACY[SEC_EXIST_BIT] ?
                    SEC_CAP[63:32] : 32'h0000_0000; // see [RL9] [RL18]
            end
            lowAddr(TER_IDX): begin
                wordData = PRI_LEGACY[TER_EXIST_BIT] ?
                    TER_CAP[31:0] : 32'h0000_0000; // see [RL11] [RL18]
            end
            highAddr(TER_IDX): begin
                wordData = PRI_LEGACY[TER_EXIST_BIT] ?
                    TER_CAP[63:32] : 32'h0000_0000; // see [RL11]
            end
            lowAddr(PRI_TRUE_IDX): begin
                wordData = st.basicTrue ?
                    PRI_TRUE[31:0] : 32'h0000_0000; // see [RL4]
            end
            highAddr(PRI_TRUE_IDX): begin
                wordData = st.basicTrue ? PRI_TRUE[63:32] : 32'h0000_0000;
            end
            lowAddr(EXIT_TRUE_IDX): begin
                wordData = st.basicTrue ?
                    EXIT_TRUE[31:0] : 32'h0000_0000; // see [RL16]
            end
            highAddr(EXIT_TRUE_IDX): begin
                wordData = st.basicTrue ? EXIT_TRUE[63:32] : 32'h0000_0000;
            end
            lowAddr(ENTRY_TRUE_IDX): begin
                wordData = st.basicTrue ?
                    ENTRY_TRUE[31:0] : 32'h0000_0000; // see [RL17]
            end
            highAddr(ENTRY_TRUE_IDX): begin
                wordData = st.basicTrue ? ENTRY_TRUE[63:32] : 32'h0000_0000;
            end
            BASIC_HI_ADDR: wordData[BASIC_TRUE_BIT] = st.basicTrue;
            PRI_CTL_ADDR: wordData = st.priCtl;
            SEC_CTL_ADDR: wordData = st.secCtl;
            TER_CTL_LO_ADDR: wordData = st.terCtl[31:0];
            TER_CTL_HI_ADDR: wordData = st.terCtl[63:32];
            EXIT_CTL_ADDR: wordData = st.exitCtl;
            ENTRY_CTL_ADDR: wordData = st.entryCtl;
            STATUS_ADDR: wordData[ST_W-1:0] = st.status;
            default: wordHit = 1'b0;
        endcase
    end

    // A request is answered on the cycle after it is first seen
    assign ack = !st.waitReq && (busReq.read || busReq.write);

    always_comb begin
        next_st = st;
        next_st.waitReq = 1'b1;
        if (st.waitReq && (busReq.read || busReq.write)) begin
            next_st.waitReq = 1'b0;
            next_st.readData = wordHit ? wordData : 32'h0000_0000;
        end
        // Capability words other than basic bit 55 ignore writes: they are fixed by the design
        if (ack && busReq.write) begin // see [RL20]
            case (busReq.address & ~14'h0003)
                BASIC_HI_ADDR: begin
                    if (busReq.byteenable[BASIC_TRUE_BIT / 8]) begin
                        next_st.basicTrue = busReq.writedata[BASIC_TRUE_BIT];
                    end
                end
                PRI_CTL_ADDR: begin
                    next_st.priCtl = mergeBytes(st.priCtl,
                        busReq.writedata, busReq.byteenable);
                end
                SEC_CTL_ADDR: begin
                    next_st.secCtl = mergeBytes(st.secCtl,
                        busReq.writedata, busReq.byteenable);
                end
                TER_CTL_LO_ADDR: begin
                    next_st.terCtl[31:0] = mergeBytes(st.terCtl[31:0],
                        busReq.writedata, busReq.byteenable);
                end
                TER_CTL_HI_ADDR: begin
                    next_st.terCtl[63:32] = mergeBytes(st.terCtl[63:32],
                        busReq.writedata, busReq.byteenable);
                end
                EXIT_CTL_ADDR: begin
                    next_st.exitCtl = mergeBytes(st.exitCtl,
                        busReq.writedata, busReq.byteenable);
                end
                ENTRY_CTL_ADDR: begin
                    next_st.entryCtl = mergeBytes(st.entryCtl,
                        busReq.writedata, busReq.byteenable);
                end
                CMD_ADDR: begin
                    if (busReq.byteenable[0]
                        && busReq.writedata[CMD_START_BIT]) begin
                        next_st.chk = CHK_EVAL;
                        next_st.status[ST_DONE] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        case (st.chk)
            CHK_EVAL: begin
                // Controls are stable here: a write cannot land on this edge
                next_st.chk = CHK_IDLE;
                next_st.status[ST_DONE] = 1'b1;
                next_st.status[ST_FAIL] = |groupFail; // see [RL20]
                next_st.status[ST_W-1:2] = groupFail;
            end
            CHK_IDLE: begin
            end
            default: next_st.chk = CHK_IDLE;
        endcase
    end

    // Control words come up at their fixed-one defaults so plain software
    // passes the check with no set-up.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st <= '0;
            st.waitReq <= 1'b1;
            st.basicTrue <= BASIC_TRUE_RESET;
            st.priCtl <= PRI_FIXED1; // see [RL19]
            st.exitCtl <= EXIT_FIXED1; // see [RL19]
            st.entryCtl <= ENTRY_FIXED1; // see [RL19]
            st.chk <= CHK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign busRsp.readdata = st.readData;
    assign busRsp.waitrequest = st.waitReq;
    assign entryDone = st.status[ST_DONE];
    assign entryFail = st.status[ST_FAIL];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic readAck;
    assign readAck = ack && busReq.read;

    legacy_pri_ones_a: assert property ( // see [RL3]
        readAck && busReq.address == lowAddr(PRI_LEGACY_IDX)
        |-> (busRsp.readdata & PRI_FIXED1) == PRI_FIXED1)
        else $error("legacy primary report lost a fixed-one bit");

    legacy_exit_ones_a: assert property ( // see [RL12]
        readAck && busReq.address == lowAddr(EXIT_LEGACY_IDX)
        |-> (busRsp.readdata & EXIT_FIXED1) == EXIT_FIXED1)
        else $error("legacy exit report lost a fixed-one bit");

    legacy_entry_ones_a: assert property ( // see [RL13]
        readAck && busReq.address == lowAddr(ENTRY_LEGACY_IDX)
        |-> (busRsp.readdata & ENTRY_FIXED1) == ENTRY_FIXED1)
        else $error("legacy entry report lost a fixed-one bit");

    sec_low_zero_a: assert property ( // see [RL6]
        readAck && busReq.address == lowAddr(SEC_IDX)
        |-> busRsp.readdata == 32'h0000_0000)
        else $error("secondary report low half not zero");

    sec_reserved_a: assert property ( // see [RL7]
        readAck && busReq.address == highAddr(SEC_IDX)
        |-> (busRsp.readdata & SEC_RESERVED) == 32'h0000_0000)
        else $error("reserved secondary bit reported as allowed");

    true_hidden_a: assert property ( // see [RL4]
        readAck && !st.basicTrue
        && busReq.address == highAddr(PRI_TRUE_IDX)
        |-> busRsp.readdata == 32'h0000_0000)
        else $error("true report visible while bit 55 is clear");

    exit_hidden_a: assert property ( // see [RL4]
        readAck && !st.basicTrue
        && busReq.address == highAddr(EXIT_TRUE_IDX)
        |-> busRsp.readdata == 32'h0000_0000)
        else $error("true exit report visible while bit 55 is clear");

    entry_hidden_a: assert property ( // see [RL4]
        readAck && !st.basicTrue
        && busReq.address == highAddr(ENTRY_TRUE_IDX)
        |-> busRsp.readdata == 32'h0000_0000)
        else $error("true entry report visible while bit 55 is clear");

    exit_zero_a: assert property ( // see [RL1]
        st.chk == CHK_EVAL && !st.basicTrue
        && (~st.exitCtl & EXIT_FIXED1) != 32'h0000_0000
        |=> entryFail)
        else $error("exit control at 0 against a required 1 passed");

    exit_one_a: assert property ( // see [RL2]
        st.chk == CHK_EVAL
        && (st.exitCtl & ~EXIT_TRUE[63:32]) != 32'h0000_0000
        |=> entryFail)
        else $error("exit control beyond allowed 1-setting passed");

    fixed_fail_a: assert property ( // see [RL4]
        st.chk == CHK_EVAL && !st.basicTrue
        && (st.priCtl & PRI_FIXED1) != PRI_FIXED1
        |=> entryFail && entryDone)
        else $error("fixed-one primary control at 0 did not fail");

    sec_gate_a: assert property ( // see [RL8]
        st.chk == CHK_EVAL && !st.priCtl[SEC_ENABLE_BIT]
        |=> !st.status[3])
        else $error("secondary failure without second-tier enable");

    sec_fail_a: assert property ( // see [RL8]
        st.chk == CHK_EVAL && st.priCtl[SEC_ENABLE_BIT]
        && (st.secCtl & SEC_RESERVED) != 32'h0000_0000
        |=> st.status[3] && entryFail)
        else $error("reserved secondary control at 1 passed");

    ter_gate_a: assert property ( // see [RL10]
        st.chk == CHK_EVAL && !st.priCtl[TER_ENABLE_BIT]
        |=> !st.status[4])
        else $error("tertiary failure without third-tier enable");

    ter_fail_a: assert property ( // see [RL10]
        st.chk == CHK_EVAL && st.priCtl[TER_ENABLE_BIT]
        && (st.terCtl & ~TER_CAP) != 64'h0000_0000_0000_0000
        |=> st.status[4] && entryFail)
        else $error("tertiary violation not reported");

    entry_one_a: assert property ( // see [RL14]
        st.chk == CHK_EVAL
        && (st.entryCtl & ~entrySel[63:32]) != 32'h0000_0000
        |=> entryFail)
        else $error("entry control beyond allowed 1-setting passed");

    check_latency_a: assert property ( // see [RL20]
        ack && busReq.write && busReq.address == CMD_ADDR
        && busReq.byteenable[0] && busReq.writedata[CMD_START_BIT]
        |=> !entryDone ##1 entryDone)
        else $error("check result not ready two edges after start");

    bus_ack_a: assert property (
        !busRsp.waitrequest |=> busRsp.waitrequest)
        else $error("waitrequest held low for more than one cycle");

endmodule : virt_control_capability_check

`default_nettype wire

//--- logic/virt_cap_pkg.sv
// Constants, capability values and carrier types for the control capability
// check block. Assumes a 32-bit Avalon-MM master with byte addressing.
package virt_cap_pkg;

    localparam int ADDR_W = 14;

    // Printed register indices; the low half sits at byte 4*index and the
    // high half at the same byte address plus HIGH_HALF_BASE.
    localparam logic [11:0] PRI_LEGACY_IDX = 12'h0482;
    localparam logic [11:0] EXIT_LEGACY_IDX = 12'h0483;
    localparam logic [11:0] ENTRY_LEGACY_IDX = 12'h0484;
    localparam logic [11:0] SEC_IDX = 12'h048B;
    localparam logic [11:0] PRI_TRUE_IDX = 12'h048E;
    localparam logic [11:0] EXIT_TRUE_IDX = 12'h048F;
    localparam logic [11:0] ENTRY_TRUE_IDX = 12'h0490;
    localparam logic [11:0] TER_IDX = 12'h0492;
    localparam logic [ADDR_W-1:0] HIGH_HALF_BASE = 14'h2000;

    // Writable control and command words; status word is read-only
    localparam logic [ADDR_W-1:0] BASIC_HI_ADDR = 14'h0004;
    localparam logic [ADDR_W-1:0] PRI_CTL_ADDR = 14'h0010;
    localparam logic [ADDR_W-1:0] SEC_CTL_ADDR = 14'h0014;
    localparam logic [ADDR_W-1:0] TER_CTL_LO_ADDR = 14'h0018;
    localparam logic [ADDR_W-1:0] TER_CTL_HI_ADDR = 14'h001C;
    localparam logic [ADDR_W-1:0] EXIT_CTL_ADDR = 14'h0020;
    localparam logic [ADDR_W-1:0] ENTRY_CTL_ADDR = 14'h0024;
    localparam logic [ADDR_W-1:0] CMD_ADDR = 14'h0028;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 14'h002C;

    // Bit 55 of the basic capability word, seen in its high half
    localparam int BASIC_TRUE_BIT = 23;
    localparam logic BASIC_TRUE_RESET = 1'b1;
    localparam int CMD_START_BIT = 0;
    localparam int SEC_ENABLE_BIT = 31;
    localparam int TER_ENABLE_BIT = 17;
    localparam int SEC_EXIST_BIT = 63;
    localparam int TER_EXIST_BIT = 49;

    // Fixed-one class masks of the low halves; reserved secondary high-half mask
    localparam logic [31:0] PRI_FIXED1 = 32'h0401_E172;
    localparam logic [31:0] EXIT_FIXED1 = 32'h0003_6DFF;
    localparam logic [31:0] ENTRY_FIXED1 = 32'h0000_11FF;
    localparam logic [31:0] SEC_RESERVED = 32'hFFFF_0000;

    // Implementation-fixed allowed settings (plain defaults)
    localparam logic [63:0] PRI_TRUE = 64'hFFFF_FFFF_0000_0000;
    localparam logic [63:0] EXIT_TRUE = 64'h003F_FFFF_0000_0000;
    localparam logic [63:0] ENTRY_TRUE = 64'h0000_FFFF_0000_0000;
    localparam logic [63:0] SEC_RAW = 64'h0000_FFFF_0000_0000;
    localparam logic [63:0] TER_CAP = 64'h0000_0000_0000_00FF;

    localparam logic [63:0] PRI_LEGACY = PRI_TRUE | {32'h0000_0000, PRI_FIXED1};
    localparam logic [63:0] EXIT_LEGACY = EXIT_TRUE | {32'h0000_0000, EXIT_FIXED1};
    localparam logic [63:0] ENTRY_LEGACY =
        ENTRY_TRUE | {32'h0000_0000, ENTRY_FIXED1};
    localparam logic [63:0] SEC_CAP = {SEC_RAW[63:32] & ~SEC_RESERVED,
                                       32'h0000_0000};

    localparam int ST_DONE = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_W = 7;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avalon_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } avalon_rsp_type;

endpackage : virt_cap_pkg

//--- bench/testbench.sv
// Self-checking bench for the capability report and entry check block.
// Assumes an Avalon-MM slave; each access waits on waitrequest, any latency.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import virt_cap_pkg::*;

    localparam logic [31:0] P0 = 32'h0401_E172;
    localparam logic [31:0] X0 = 32'h0003_6DFF;
    localparam logic [31:0] N0 = 32'h0000_11FF;
    localparam logic [31:0] Z  = 32'h0000_0000;
    localparam logic [31:0] SE = 32'h8000_0000;
    localparam logic [31:0] TE = 32'h0002_0000;
    localparam logic [31:0] PC = 32'h0001_E172;

    logic           ref_clk;
    logic           rst;
    avalon_req_type busReq;
    avalon_rsp_type busRsp;
    logic           entryDone;
    logic           entryFail;
    int             nMismatch;
    int             samplesChecked;
    int             cycles;
    int             i;
    logic [31:0]    d;
    logic [63:0]    v;
    logic [11:0]    idxTab [8] = '{12'h482, 12'h483, 12'h484, 12'h48B,
                                   12'h48E, 12'h48F, 12'h490, 12'h492};
    logic [63:0]    expTab [8];

    virt_control_capability_check DUT (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .busReq    (busReq),
        .busRsp    (busRsp),
        .entryDone (entryDone),
        .entryFail (entryFail)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", nMismatch, samplesChecked);
        if (nMismatch == 0 && samplesChecked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // Cuts a hung handshake short; the whole run needs a little over 500 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nMismatch = nMismatch + 1;
            $display("unexpected timeout expected finish seen hang");
            conclude();
        end
    end

    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Request held until the edge where waitrequest is sampled low
    task automatic bus_access(input logic [13:0] a, input logic wr,
                              input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge ref_clk);
        busReq <= '{address: a, read: ~wr, write: wr, writedata: wd,
                    byteenable: 4'hF};
        do begin
            @(posedge ref_clk);
        end while (busRsp.waitrequest !== 1'b0);
        rdat = busRsp.readdata;
        busReq.read <= 1'b0;
        busReq.write <= 1'b0;
    endtask : bus_access

    task automatic read64(input logic [11:0] idx, output logic [63:0] val);
        logic [13:0] a;
        a = {idx, 2'b00};
        bus_access(a, 1'b0, Z, val[31:0]);
        bus_access(a + HIGH_HALF_BASE, 1'b0, Z, val[63:32]);
    endtask : read64

    task automatic run(input logic bt, input logic [31:0] pri, sec, tlo, thi,
                       input logic [31:0] ext, ent, input logic expFail);
        logic [31:0] r;
        int n;
        bus_access(BASIC_HI_ADDR, 1'b1, 32'(bt) << BASIC_TRUE_BIT, r);
        bus_access(PRI_CTL_ADDR, 1'b1, pri, r);
        bus_access(SEC_CTL_ADDR, 1'b1, sec, r);
        bus_access(TER_CTL_LO_ADDR, 1'b1, tlo, r);
        bus_access(TER_CTL_HI_ADDR, 1'b1, thi, r);
        bus_access(EXIT_CTL_ADDR, 1'b1, ext, r);
        bus_access(ENTRY_CTL_ADDR, 1'b1, ent, r);
        bus_access(CMD_ADDR, 1'b1, 32'h0000_0001, r);
        @(posedge ref_clk);
        check("entryDone low", 64'h0, {63'h0, entryDone});
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (entryDone !== 1'b1 && n < 8);
        check("entryFail", {63'h0, expFail}, {63'h0, entryFail});
        bus_access(STATUS_ADDR, 1'b0, Z, r);
        check("status", {62'h0, expFail, 1'b1}, 64'(r[1:0]));
    endtask : run

    initial begin
        busReq = '0;
        rst = 1'b1;
        cycles = 0;
        nMismatch = 0;
        samplesChecked = 0;
        expTab = '{{PRI_TRUE[63:32], PRI_TRUE[31:0] | P0},
                   {EXIT_TRUE[63:32], EXIT_TRUE[31:0] | X0},
                   {ENTRY_TRUE[63:32], ENTRY_TRUE[31:0] | N0},
                   {SEC_RAW[63:32] & 32'h0000_FFFF, Z},
                   PRI_TRUE, EXIT_TRUE, ENTRY_TRUE, TER_CAP};
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check("idle wait", 64'h1, {63'h0, busRsp.waitrequest});
        check("reset done", 64'h0, {62'h0, entryDone, entryFail});
        // Full map with the true reports present
        for (i = 0; i < 8; i++) begin
            read64(idxTab[i], v);
            check("report", expTab[i], v);
        end
        // Writes to a report and to a hole must leave no trace
        bus_access(14'h1208, 1'b1, 32'hFFFF_FFFF, d);
        read64(12'h482, v);
        check("report after write", expTab[0], v);
        bus_access(14'h0100, 1'b1, 32'hFFFF_FFFF, d);
        bus_access(14'h0100, 1'b0, Z, d);
        check("unmapped", 64'h0, {32'h0, d});
        // Basic bit 55 clear withdraws the true reports
        bus_access(BASIC_HI_ADDR, 1'b1, Z, d);
        bus_access(BASIC_HI_ADDR, 1'b0, Z, d);
        check("basic bit", 64'h0, {63'h0, d[BASIC_TRUE_BIT]});
        for (i = 4; i < 7; i++) begin
            read64(idxTab[i], v);
            check("absent true report", 64'h0, v);
        end
        read64(12'h483, v);
        check("legacy kept", expTab[1], v);
        run(1'b1, P0, Z, Z, Z, X0, N0, 1'b0);
        run(1'b0, P0, Z, Z, Z, X0, N0, 1'b0);
        run(1'b0, PC, Z, Z, Z, X0, N0, 1'b1);
        run(1'b1, PC, Z, Z, Z, X0, N0, 1'b0);
        run(1'b0, P0, Z, Z, Z, X0 & ~32'h0000_0001, N0, 1'b1);
        run(1'b0, P0, Z, Z, Z, X0, N0 & ~32'h0000_1000, 1'b1);
        run(1'b1, P0, Z, Z, Z, X0 | 32'h0040_0000, N0, 1'b1);
        run(1'b1, P0, Z, Z, Z, X0, N0 | 32'h0001_0000, 1'b1);
        run(1'b1, P0, 32'h0001_0000, Z, Z, X0, N0, 1'b0);
        run(1'b1, P0 | SE, 32'h0001_0000, Z, Z, X0, N0, 1'b1);
        run(1'b1, P0 | SE, 32'h0000_FFFF, Z, Z, X0, N0, 1'b0);
        run(1'b1, P0, Z, 32'h0000_0100, Z, X0, N0, 1'b0);
        run(1'b1, P0 | TE, Z, 32'h0000_0100, Z, X0, N0, 1'b1);
        run(1'b1, P0 | TE, Z, 32'h0000_00FF, Z, X0, N0, 1'b0);
        run(1'b1, P0 | TE, Z, Z, 32'h0000_0001, X0, N0, 1'b1);
        conclude();
    end

endmodule : testbench

`default_nettype wire
